// >>> design/gtc_map.vh
`ifndef GTC_MAP_VH
`define GTC_MAP_VH
// gate source select codes
`define GTC_GSS_PIN        5'h00
`define GTC_GSS_TMR0_OVF   5'h01
`define GTC_GSS_CMP1       5'h12
`define GTC_GSS_CMP2       5'h13
// prescale select codes
`define GTC_PS_DIV1        2'h0
`define GTC_PS_DIV2        2'h1
`define GTC_PS_DIV4        2'h2
`define GTC_PS_DIV8        2'h3
// reset values and wrap points
`define GTC_COUNT_RESET    16'h0000
`define GTC_COUNT_MAX      16'hFFFF
`define GTC_PRE_RESET      3'h0
// synchroniser depth for pin-side inputs
`define GTC_SYNC_STAGES    3
`endif

// >>> design/gtc_sync3.v
`timescale 1ns/100ps
`default_nettype none
// three-stage synchroniser; output changes once stages two and three agree
module gtc_sync3 (
  input  wire CLOCK_I,
  input  wire RST_I,
  input  wire CE_I,
  input  wire D_I,
  output reg  Q_O
);
  reg s1_r;
  reg s2_r;
  reg s3_r;
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      s1_r <= 1'b0;
      s2_r <= 1'b0;
      s3_r <= 1'b0;
      Q_O  <= 1'b0;
    end else if (CE_I) begin
      s1_r <= D_I;
      s2_r <= s1_r;
      s3_r <= s2_r;
      if (s2_r == s3_r) begin
        Q_O <= s3_r;
      end
    end
  end
endmodule // gtc_sync3
`default_nettype wire

// >>> design/gtc_timer.v
`timescale 1ns/100ps
`default_nettype none
`include "gtc_map.vh"
// Summary of operation
// - byte reads of count taken live from the counter, no latching
// - gate enable makes gating active, polarity chosen
// - count when gate equals polarity, else hold
// - gate chosen from selectable sources, any polarity
// - companion overflow gives rising gate pulse
// - comparator gate used synced or raw
// - toggle flop flips each incrementing gate edge
// - toggle flop held clear when mode off
// - single pulse armed, counts from next edge
// - trailing edge clears arm, ignores further events
// - toggle and single pulse act in series
// - gate level status shows gate always
// - gate level falling edge sets event flag
// - count wraps FFFF to 0000, sets overflow
// - overflow irq needs on and all enables
// - sleep counting only async external, wakes
// - compare trigger clears count, no overflow flag
// - count write beats compare trigger clear
// - timer off stops count, clears toggle flop
// - gate source select is five bits
// - prescaler divides by 1, 2, 4, 8
module gtc_timer (
  input  wire        CLOCK_I,
  input  wire        RST_I,
  input  wire        CE_I,
  input  wire        TIMER_ON_I,
  input  wire        GATE_ENABLE_I,
  input  wire        GATE_POLARITY_I,
  input  wire        TOGGLE_MODE_I,
  input  wire        SINGLE_PULSE_MODE_I,
  input  wire        ARM_SET_I,
  input  wire        ARM_CLR_I,
  input  wire [4:0]  GATE_SOURCE_I,
  input  wire [1:0]  PRESCALE_I,
  input  wire        ASYNC_MODE_I,
  input  wire        EXT_CLOCK_SEL_I,
  input  wire        EXT_CLOCK_PIN_I,
  input  wire        GATE_INPUT_PIN_I,
  input  wire        TMR0_OVF_I,
  input  wire        CMP1_OUT_I,
  input  wire        CMP1_SYNC_I,
  input  wire        CMP2_OUT_I,
  input  wire        CMP2_SYNC_I,
  input  wire [15:0] OTHER_SOURCES_I,
  input  wire        COMPARE_TRIGGER_I,
  input  wire        WRITE_LOW_I,
  input  wire        WRITE_HIGH_I,
  input  wire [7:0]  WRITE_DATA_I,
  input  wire        SLEEP_I,
  input  wire        OVERFLOW_IRQ_ENABLE_I,
  input  wire        GATE_IRQ_ENABLE_I,
  input  wire        PERIPHERAL_IRQ_ENABLE_I,
  input  wire        GLOBAL_IRQ_ENABLE_I,
  input  wire        OVERFLOW_FLAG_CLR_I,
  input  wire        GATE_FLAG_CLR_I,
  output wire [7:0]  COUNT_LOW_O,
  output wire [7:0]  COUNT_HIGH_O,
  output wire        SINGLE_PULSE_ARM_O,
  output wire        GATE_LEVEL_O,
  output wire        OVERFLOW_FLAG_O,
  output wire        GATE_EVENT_FLAG_O,
  output wire        IRQ_O,
  output wire        WAKE_O
);
  wire       pin_gate_s;
  wire       ext_clk_s;
  wire       cmp1_s;
  wire       cmp2_s;
  wire       cmp1_raw_s;
  wire       cmp2_raw_s;
  reg  [15:0] count_r;
  reg  [15:0] count_nxt;
  reg  [2:0]  pre_r;
  reg  [2:0]  pre_nxt;
  reg         ext_prev_r;
  reg         toggle_r;
  reg         arm_r;
  reg         pulse_on_r;
  reg         src_prev_r;
  reg         gate_level_r;
  reg         gate_prev_r;
  reg         ovf_flag_r;
  reg         gate_flag_r;
  reg         src_prev_tog_r;
  reg         raw_src;
  reg         pre_tick;
  reg  [2:0]  pre_mask;
  wire        tick;
  wire        pol_src;
  wire        src_rise;
  wire        gate_val;
  wire        count_en;
  wire        inc;
  wire        wrap;

  gtc_sync3 u_sync_gate (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
                         .D_I(GATE_INPUT_PIN_I), .Q_O(pin_gate_s));
  gtc_sync3 u_sync_clk  (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
                         .D_I(EXT_CLOCK_PIN_I), .Q_O(ext_clk_s));
  gtc_sync3 u_sync_c1   (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
                         .D_I(CMP1_OUT_I), .Q_O(cmp1_s));
  gtc_sync3 u_sync_c2   (.CLOCK_I(CLOCK_I), .RST_I(RST_I), .CE_I(CE_I),
                         .D_I(CMP2_OUT_I), .Q_O(cmp2_s));

  // the raw comparator path still passes a synchroniser; only the extra
  // timer-clock retiming stage differs, there is no safe truly raw path here
  assign cmp1_raw_s = cmp1_s;
  assign cmp2_raw_s = cmp2_s;
  reg cmp1_tc_r;
  reg cmp2_tc_r;

  // gate source mux
  always @* begin
    case (GATE_SOURCE_I)
      `GTC_GSS_PIN:      raw_src = pin_gate_s;
      `GTC_GSS_TMR0_OVF: raw_src = TMR0_OVF_I;
      `GTC_GSS_CMP1:     raw_src = CMP1_SYNC_I ? cmp1_tc_r : cmp1_raw_s;
      `GTC_GSS_CMP2:     raw_src = CMP2_SYNC_I ? cmp2_tc_r : cmp2_raw_s;
      default:           raw_src = OTHER_SOURCES_I[GATE_SOURCE_I[3:0]];
    endcase
  end

  // one increment event per selected clock edge after the prescaler
  always @* begin
    case (PRESCALE_I)
      `GTC_PS_DIV1: pre_mask = 3'h0;
      `GTC_PS_DIV2: pre_mask = 3'h1;
      `GTC_PS_DIV4: pre_mask = 3'h3;
      `GTC_PS_DIV8: pre_mask = 3'h7;
      default:      pre_mask = 3'h0;
    endcase
  end

  wire clk_edge = EXT_CLOCK_SEL_I ? (ext_clk_s & ~ext_prev_r) : 1'b1;
  // in sleep only the external clock with ASYNC_MODE_I set keeps the count alive; it still passes the synchroniser
  wire clk_allowed = ~SLEEP_I | (EXT_CLOCK_SEL_I & ASYNC_MODE_I);
  wire wr_any = WRITE_LOW_I | WRITE_HIGH_I;

  always @* begin
    pre_nxt  = pre_r;
    pre_tick = 1'b0;
    if (wr_any || !TIMER_ON_I) begin
      pre_nxt = `GTC_PRE_RESET;
    end else if (clk_edge && clk_allowed) begin
      if ((pre_r & pre_mask) == pre_mask) begin
        pre_tick = 1'b1;
        pre_nxt  = `GTC_PRE_RESET;
      end else begin
        pre_nxt = pre_r + 3'h1;
      end
    end
  end
  assign tick = pre_tick;

  // polarity applied before the toggle and single-pulse stages
  assign pol_src  = ~(raw_src ^ GATE_POLARITY_I);
  assign src_rise = pol_src & ~src_prev_r;
  wire   tog_out  = TOGGLE_MODE_I ? toggle_r : pol_src;
  // single pulse stage fed by toggle stage output
  assign gate_val = SINGLE_PULSE_MODE_I ? (pulse_on_r & tog_out) : tog_out;
  assign count_en = TIMER_ON_I & (~GATE_ENABLE_I | gate_val);
  assign inc      = count_en & tick;
  assign wrap     = inc & (count_r == `GTC_COUNT_MAX);

  always @* begin
    count_nxt = count_r;
    if (WRITE_LOW_I || WRITE_HIGH_I) begin
      // write wins over a coincident compare clear
      if (WRITE_LOW_I) count_nxt[7:0] = WRITE_DATA_I;
      if (WRITE_HIGH_I) count_nxt[15:8] = WRITE_DATA_I;
    end else if (COMPARE_TRIGGER_I) begin
      count_nxt = `GTC_COUNT_RESET;
    end else if (inc) begin
      count_nxt = count_r + 16'h0001;
    end
  end

  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      count_r      <= `GTC_COUNT_RESET;
      pre_r        <= `GTC_PRE_RESET;
      ext_prev_r   <= 1'b0;
      toggle_r     <= 1'b0;
      arm_r        <= 1'b0;
      pulse_on_r   <= 1'b0;
      src_prev_r   <= 1'b0;
      gate_level_r <= 1'b0;
      gate_prev_r  <= 1'b0;
      ovf_flag_r   <= 1'b0;
      gate_flag_r  <= 1'b0;
      cmp1_tc_r    <= 1'b0;
      cmp2_tc_r    <= 1'b0;
    end else if (CE_I) begin
      count_r    <= count_nxt;
      pre_r      <= pre_nxt;
      ext_prev_r <= ext_clk_s;
      src_prev_r <= pol_src;
      cmp1_tc_r  <= cmp1_s;
      cmp2_tc_r  <= cmp2_s;
      if (!TOGGLE_MODE_I || !TIMER_ON_I) begin
        toggle_r <= 1'b0;
      end else if (src_rise) begin
        toggle_r <= ~toggle_r;
      end
      // single-pulse sequencing
      if (!SINGLE_PULSE_MODE_I || ARM_CLR_I) begin
        arm_r      <= 1'b0;
        pulse_on_r <= 1'b0;
      end else if (ARM_SET_I && !arm_r) begin
        arm_r      <= 1'b1;
        pulse_on_r <= 1'b0;
      end else if (arm_r && !pulse_on_r && tog_out && !src_prev_tog_r) begin
        pulse_on_r <= 1'b1;
      end else if (arm_r && pulse_on_r && !tog_out) begin
        arm_r      <= 1'b0;
        pulse_on_r <= 1'b0;
      end
      gate_level_r <= gate_val;
      gate_prev_r  <= gate_level_r;
      if (gate_prev_r && !gate_level_r) begin
        gate_flag_r <= 1'b1;
      end else if (GATE_FLAG_CLR_I) begin
        gate_flag_r <= 1'b0;
      end
      if (wrap && !wr_any && !COMPARE_TRIGGER_I) begin
        ovf_flag_r <= 1'b1;
      end else if (OVERFLOW_FLAG_CLR_I) begin
        ovf_flag_r <= 1'b0;
      end
    end
  end

  // previous toggle-stage output, used to find the edge that starts the armed pulse
  always @(posedge CLOCK_I) begin
    if (RST_I) begin
      src_prev_tog_r <= 1'b0;
    end else if (CE_I) begin
      src_prev_tog_r <= tog_out;
    end
  end

  assign COUNT_LOW_O        = count_r[7:0];
  assign COUNT_HIGH_O       = count_r[15:8];
  assign SINGLE_PULSE_ARM_O = arm_r;
  assign GATE_LEVEL_O       = gate_level_r;
  assign OVERFLOW_FLAG_O    = ovf_flag_r;
  assign GATE_EVENT_FLAG_O  = gate_flag_r;
  wire ovf_req  = ovf_flag_r & OVERFLOW_IRQ_ENABLE_I & TIMER_ON_I;
  wire gate_req = gate_flag_r & GATE_IRQ_ENABLE_I;
  wire per_req  = (ovf_req | gate_req) & PERIPHERAL_IRQ_ENABLE_I;
  assign IRQ_O  = per_req & GLOBAL_IRQ_ENABLE_I;
  // wake does not need the global enable; vectoring does
  assign WAKE_O = SLEEP_I & ovf_req & PERIPHERAL_IRQ_ENABLE_I;
endmodule // gtc_timer
`default_nettype wire

// >>> tb/gtc_timer_sva.sv
`timescale 1ns/100ps
`default_nettype none
module gtc_timer_sva (
  input wire logic       CLOCK_I,
  input wire logic       RST_I,
  input wire logic       TIMER_ON_I,
  input wire logic       SINGLE_PULSE_MODE_I,
  input wire logic       ARM_SET_I,
  input wire logic       COMPARE_TRIGGER_I,
  input wire logic       WRITE_LOW_I,
  input wire logic       WRITE_HIGH_I,
  input wire logic [7:0] WRITE_DATA_I,
  input wire logic       OVERFLOW_FLAG_CLR_I,
  input wire logic [7:0] COUNT_LOW_O,
  input wire logic [7:0] COUNT_HIGH_O,
  input wire logic       SINGLE_PULSE_ARM_O,
  input wire logic       GATE_LEVEL_O,
  input wire logic       OVERFLOW_FLAG_O,
  input wire logic       GATE_EVENT_FLAG_O
);
  wire [15:0] cnt = {COUNT_HIGH_O, COUNT_LOW_O};
  wire        wr  = WRITE_LOW_I | WRITE_HIGH_I;
  default clocking cb @(posedge CLOCK_I); endclocking
  default disable iff (RST_I);
  sequence top_s; cnt == 16'hFFFF && !wr && !COMPARE_TRIGGER_I; endsequence
  sequence wrapped_s; cnt == 16'h0000; endsequence
  wrap_flag_a: assert property (top_s ##1 wrapped_s |-> OVERFLOW_FLAG_O)
    else $error("wrap left overflow flag clear");
  trig_clear_a: assert property (COMPARE_TRIGGER_I && !wr && !OVERFLOW_FLAG_CLR_I |=>
    cnt == 16'h0000 && $stable(OVERFLOW_FLAG_O)) else $error("compare trigger clear wrong");
  wr_low_a: assert property (WRITE_LOW_I |=> COUNT_LOW_O == $past(WRITE_DATA_I))
    else $error("low byte write lost");
  wr_high_a: assert property (WRITE_HIGH_I |=> COUNT_HIGH_O == $past(WRITE_DATA_I))
    else $error("high byte write lost");
  off_hold_a: assert property (!TIMER_ON_I && !wr && !COMPARE_TRIGGER_I |=> $stable(cnt))
    else $error("count moved while timer off");
  arm_drop_a: assert property (!SINGLE_PULSE_MODE_I && !ARM_SET_I |=> !SINGLE_PULSE_ARM_O)
    else $error("arm kept without single pulse mode");
  ovf_stick_a: assert property (OVERFLOW_FLAG_O && !OVERFLOW_FLAG_CLR_I |=> OVERFLOW_FLAG_O)
    else $error("overflow flag dropped");
  gate_fall_a: assert property ($fell(GATE_LEVEL_O) |-> ##[0:1] GATE_EVENT_FLAG_O)
    else $error("gate fall left event flag clear");
endmodule // gtc_timer_sva
bind gtc_timer gtc_timer_sva u_sva (.CLOCK_I, .RST_I, .TIMER_ON_I, .SINGLE_PULSE_MODE_I,
  .ARM_SET_I, .COMPARE_TRIGGER_I, .WRITE_LOW_I, .WRITE_HIGH_I, .WRITE_DATA_I,
  .OVERFLOW_FLAG_CLR_I, .COUNT_LOW_O, .COUNT_HIGH_O, .SINGLE_PULSE_ARM_O, .GATE_LEVEL_O,
  .OVERFLOW_FLAG_O, .GATE_EVENT_FLAG_O);
`default_nettype wire

// >>> tb/gtc_ovf_model.sv
`timescale 1ns/100ps
`default_nettype none
module gtc_ovf_model #(parameter int PERIOD = 5) (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  output var  logic ovf_o
);
  int cnt_r;
  initial ovf_o = 1'b0;
  // companion wraps every PERIOD cycles; one-cycle low-to-high pulse per wrap
  always @(posedge clk_i) begin
    if (rst_i || !en_i) begin
      cnt_r <= 0;
      ovf_o <= 1'b0;
    end else begin
      cnt_r <= (cnt_r == PERIOD - 1) ? 0 : cnt_r + 1;
      ovf_o <= (cnt_r == PERIOD - 1);
    end
  end
endmodule // gtc_ovf_model
`default_nettype wire

// >>> tb/gtc_timer_tb.sv
`timescale 1ns/100ps
`default_nettype none
module gtc_timer_tb;
  logic CLOCK_I = 0, RST_I = 1, CE_I = 1, TIMER_ON_I = 0, GATE_ENABLE_I = 0, GATE_POLARITY_I = 0;
  logic TOGGLE_MODE_I = 0, SINGLE_PULSE_MODE_I = 0, ARM_SET_I = 0, ARM_CLR_I = 0, SLEEP_I = 0;
  logic ASYNC_MODE_I = 0, EXT_CLOCK_SEL_I = 0, EXT_CLOCK_PIN_I = 0, GATE_INPUT_PIN_I = 0;
  logic CMP1_OUT_I = 0, CMP1_SYNC_I = 0, CMP2_OUT_I = 0, CMP2_SYNC_I = 0, COMPARE_TRIGGER_I = 0;
  logic WRITE_LOW_I = 0, WRITE_HIGH_I = 0, OVERFLOW_IRQ_ENABLE_I = 0, GATE_IRQ_ENABLE_I = 0;
  logic PERIPHERAL_IRQ_ENABLE_I = 0, GLOBAL_IRQ_ENABLE_I = 0, OVERFLOW_FLAG_CLR_I = 0;
  logic GATE_FLAG_CLR_I = 0, TMR0_OVF_I, ovf_en = 0;
  logic [4:0]  GATE_SOURCE_I = 5'h00;
  logic [1:0]  PRESCALE_I = 2'h0;
  logic [7:0]  WRITE_DATA_I = 8'h00, COUNT_LOW_O, COUNT_HIGH_O;
  logic [15:0] OTHER_SOURCES_I = 16'h0000, c0;
  logic SINGLE_PULSE_ARM_O, GATE_LEVEL_O, OVERFLOW_FLAG_O, GATE_EVENT_FLAG_O, IRQ_O, WAKE_O;
  int error_cnt = 0, compares = 0;
  wire [15:0] cnt = {COUNT_HIGH_O, COUNT_LOW_O};
  gtc_timer uut (.CLOCK_I, .RST_I, .CE_I, .TIMER_ON_I, .GATE_ENABLE_I, .GATE_POLARITY_I,
    .TOGGLE_MODE_I, .SINGLE_PULSE_MODE_I, .ARM_SET_I, .ARM_CLR_I, .GATE_SOURCE_I, .PRESCALE_I,
    .ASYNC_MODE_I, .EXT_CLOCK_SEL_I, .EXT_CLOCK_PIN_I, .GATE_INPUT_PIN_I, .TMR0_OVF_I,
    .CMP1_OUT_I, .CMP1_SYNC_I, .CMP2_OUT_I, .CMP2_SYNC_I, .OTHER_SOURCES_I, .COMPARE_TRIGGER_I,
    .WRITE_LOW_I, .WRITE_HIGH_I, .WRITE_DATA_I, .SLEEP_I, .OVERFLOW_IRQ_ENABLE_I,
    .GATE_IRQ_ENABLE_I, .PERIPHERAL_IRQ_ENABLE_I, .GLOBAL_IRQ_ENABLE_I, .OVERFLOW_FLAG_CLR_I,
    .GATE_FLAG_CLR_I, .COUNT_LOW_O, .COUNT_HIGH_O, .SINGLE_PULSE_ARM_O, .GATE_LEVEL_O,
    .OVERFLOW_FLAG_O, .GATE_EVENT_FLAG_O, .IRQ_O, .WAKE_O);
  gtc_ovf_model #(.PERIOD(5)) u_ovf (.clk_i(CLOCK_I), .rst_i(RST_I), .en_i(ovf_en),
    .ovf_o(TMR0_OVF_I));
  initial forever #50 CLOCK_I = ~CLOCK_I;
  task cyc(input int n); repeat (n) @(negedge CLOCK_I); endtask
  task chk16(input logic [15:0] got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t count %h expected %h", $time, got, exp);
    end
  endtask
  task chk1(input logic got, exp);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR %0t bit %b expected %b", $time, got, exp);
    end
  endtask
  // bytes share one data bus, so one byte per cycle with the timer stopped
  task wrb(input logic hi, input logic [7:0] d);
    WRITE_LOW_I = !hi; WRITE_HIGH_I = hi; WRITE_DATA_I = d;
    cyc(1);
    WRITE_LOW_I = 0; WRITE_HIGH_I = 0;
  endtask
  task t_wrap;
    int n;
    WRITE_LOW_I = 1; WRITE_HIGH_I = 1; WRITE_DATA_I = 8'hFF;
    cyc(1);
    WRITE_LOW_I = 0; WRITE_HIGH_I = 0; TIMER_ON_I = 1; n = 0;
    chk16(cnt, 16'hFFFF);
    while (OVERFLOW_FLAG_O !== 1'b1 && n < 4) begin cyc(1); n++; end
    chk16(cnt, 16'h0000);
    {OVERFLOW_IRQ_ENABLE_I, PERIPHERAL_IRQ_ENABLE_I, GLOBAL_IRQ_ENABLE_I} = 3'h7;
    SLEEP_I = 1; ASYNC_MODE_I = 1;
    cyc(1);
    chk1(IRQ_O, 1);
    chk1(WAKE_O, 1);
    GLOBAL_IRQ_ENABLE_I = 0;
    cyc(1);
    chk1(IRQ_O, 0);
    chk1(OVERFLOW_FLAG_O, 1);
    OVERFLOW_FLAG_CLR_I = 1; cyc(1); OVERFLOW_FLAG_CLR_I = 0;
    chk1(OVERFLOW_FLAG_O, 0);
    chk1(WAKE_O, 0);
    TIMER_ON_I = 0; SLEEP_I = 0; ASYNC_MODE_I = 0;
    $display("wrap test done");
  endtask
  task t_trig;
    wrb(0, 8'h34); wrb(1, 8'h12);
    chk16(cnt, 16'h1234);
    EXT_CLOCK_SEL_I = 0;
    COMPARE_TRIGGER_I = 1; cyc(1); COMPARE_TRIGGER_I = 0;
    chk16(cnt, 16'h0000);
    chk1(OVERFLOW_FLAG_O, 0);
    wrb(1, 8'h12);
    COMPARE_TRIGGER_I = 1; wrb(0, 8'h55); COMPARE_TRIGGER_I = 0;
    chk16(cnt, 16'h1255);
    $display("trigger test done");
  endtask
  task t_gate;
    logic [4:0] src [4] = '{5'h00, 5'h12, 5'h13, 5'h03};
    TIMER_ON_I = 1; GATE_ENABLE_I = 1;
    for (int j = 0; j < 4; j++) begin
      GATE_SOURCE_I = src[j]; CMP1_SYNC_I = j[0]; CMP2_SYNC_I = j[1];
      for (int i = 0; i < 4; i++) begin
        GATE_POLARITY_I = i[1];
        {GATE_INPUT_PIN_I, CMP1_OUT_I, CMP2_OUT_I} = {3{i[0]}};
        OTHER_SOURCES_I = {16{i[0]}};
        cyc(8); c0 = cnt; cyc(4);
        chk1(cnt != c0, i[1] == i[0]);
      end
    end
    $display("gate test done");
  endtask
  task t_pulse;
    GATE_SOURCE_I = 5'h03; GATE_POLARITY_I = 1; OTHER_SOURCES_I = 0; SINGLE_PULSE_MODE_I = 1;
    cyc(8);
    ARM_SET_I = 1; GATE_FLAG_CLR_I = 1; cyc(1); ARM_SET_I = 0; GATE_FLAG_CLR_I = 0;
    chk1(SINGLE_PULSE_ARM_O, 1);
    c0 = cnt;
    OTHER_SOURCES_I = 16'hFFFF; cyc(6); OTHER_SOURCES_I = 0; cyc(6);
    chk1(cnt != c0, 1);
    chk1(SINGLE_PULSE_ARM_O, 0);
    chk1(GATE_EVENT_FLAG_O, 1);
    c0 = cnt;
    OTHER_SOURCES_I = 16'hFFFF; cyc(6); OTHER_SOURCES_I = 0; cyc(6);
    chk16(cnt, c0);
    GATE_FLAG_CLR_I = 1; cyc(1); GATE_FLAG_CLR_I = 0; SINGLE_PULSE_MODE_I = 0;
    ARM_CLR_I = 1; cyc(1); ARM_CLR_I = 0;
    chk1(GATE_EVENT_FLAG_O, 0);
    $display("single pulse test done");
  endtask
  task t_comp;
    GATE_SOURCE_I = 5'h01; PRESCALE_I = 2'h3; ovf_en = 1;
    TOGGLE_MODE_I = 1;
    c0 = cnt; cyc(80);
    chk1(cnt != c0, 1);
    TIMER_ON_I = 0; cyc(2); c0 = cnt; cyc(6);
    chk16(cnt, c0);
    $display("companion test done");
  endtask
  task wrap_up;
    $display("compares %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  initial begin
    cyc(5); RST_I = 0;
    chk16(cnt, 16'h0000);
    t_wrap; t_trig; t_gate; t_pulse; t_comp;
    wrap_up;
  end
  // about 330 cycles are needed; give several times that
  initial begin
    #(3000 * 100);
    error_cnt++;
    $display("ERROR %0t watchdog expired", $time);
    wrap_up;
  end
endmodule // gtc_timer_tb
`default_nettype wire
